// >>> pll_clk_cfg.svh
// Constants for the PLL clock configuration block.
// Assumes a 20 MHz system clock and a plain strobe register port.
`ifndef PLL_CLK_CFG_SVH
`define PLL_CLK_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_W          8
`define OFS_CLK_CTL     8'h00
`define OFS_CLK_STATUS  8'h04

// ****************************************************************
// Field positions of the clock control register
// ****************************************************************
`define PRE_LSB         0
`define PRE_MSB         4
`define MULT_LSB        8
`define MULT_MSB        15
`define RANGE_BIT       16
`define SRC_LSB         17
`define SRC_MSB         18

// ****************************************************************
// Field positions of the status register
// ****************************************************************
`define ST_ERR_BIT      0
`define ST_DIV_LSB      1
`define ST_DIV_MSB      3
`define ST_MULT_LSB     4
`define ST_MULT_MSB     12

// ****************************************************************
// Encodings, limits and reset values
// ****************************************************************
`define PRE_MAX         5'h08
`define SRC_DIV1        2'h3
`define SRC_DIV2        2'h1
`define RST_PRE         5'h00
`define RST_MULT        8'h13
`define RST_RANGE       1'h0
`define RST_SRC         2'h1

`endif

// >>> pll_clk_pkg.sv
// Types shared by the PLL clock configuration files.
// Assumes pll_clk_cfg.svh supplies the field widths in use here.
package pll_clk_pkg;

	// One complete setting of the clock synthesis path.
	typedef struct packed {
		logic [1:0] core_source_select;
		logic       vco_range_select;
		logic [7:0] loop_multiply_factor;
		logic [4:0] pre_divide_factor;
	} clk_cfg_s;

	// Derived ratios presented to the clock tree.
	typedef struct packed {
		logic [8:0] loop_multiplier;
		logic       vco_halved;
		logic [2:0] core_division;
	} clk_ratio_s;

endpackage

// >>> tick_divider.sv
// Divides the reference clock into a one-cycle enable pulse every ratio+1 cycles.
// Assumes restart is high for one cycle whenever the ratio changes.
`timescale 1ns/1ps

module tick_divider (
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       restart,
	input  wire logic [4:0] ratio,
	output logic            tick
);

	logic [4:0] count_r;

	always_ff @(posedge sys_clk) begin
		if (srst || restart) begin
			count_r <= 5'h00;
			tick    <= 1'b0;
		end else if (count_r == ratio) begin
			count_r <= 5'h00;
			tick    <= 1'b1;
		end else begin
			count_r <= count_r + 5'h01;
			tick    <= 1'b0;
		end
	end

endmodule // tick_divider

// >>> pll_clock_configuration.sv
// Clock configuration logic: holds the clock control register and derives the ratios.
// Assumes software drives a one-cycle write or read strobe on the sys_clk domain.
//
// Notes on behaviour
// - The pre-divide field sets the input divider ratio, whose output feeds the multiplier.
// - The loop multiply field sets the multiplier ratio, whose output forms the VCO path.
// - The range select field chooses the frequency range of the PLL output.
// - The source select field chooses the source that drives the core clock.
// - A pre-divide value n divides by n+1, with encodings 0x00 to 0x08 only.
// - The loop output is the pre-divided clock times the multiply field plus one.
// - Range 1 passes the loop output as the VCO clock, range 0 halves it.
// - Source 11 with range 0 or 01 with range 1 divides by 2, 01 with range 0 by 4.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "pll_clk_cfg.svh"

module pll_clock_configuration (
	input  wire logic                       sys_clk,
	input  wire logic                       srst,
	input  wire logic [`ADDR_W-1:0]         reg_addr,
	input  wire logic [31:0]                reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [31:0]                reg_rdata,
	output logic                            pre_div_tick,
	output pll_clk_pkg::clk_ratio_s         clk_ratio,
	output logic                            config_error
);
	import pll_clk_pkg::*;

	// ****************************************************************
	// Register port
	// ****************************************************************
	clk_cfg_s   clock_control_register_r;
	clk_cfg_s   applied_r;
	clk_cfg_s   wcfg;
	logic       ctl_wr;
	logic       wcfg_ok;
	logic       apply_r;
	logic [2:0] div_nxt;

	always_comb begin
		wcfg.pre_divide_factor    = reg_wdata[`PRE_MSB:`PRE_LSB];
		wcfg.loop_multiply_factor = reg_wdata[`MULT_MSB:`MULT_LSB];
		wcfg.vco_range_select     = reg_wdata[`RANGE_BIT];
		wcfg.core_source_select   = reg_wdata[`SRC_MSB:`SRC_LSB];
	end

	assign ctl_wr = reg_wr && (reg_addr == `OFS_CLK_CTL);
	// Undocumented sources and the reserved divide-by-one pairing are never applied.
	assign wcfg_ok = (wcfg.pre_divide_factor <= `PRE_MAX) &&
		((wcfg.core_source_select == `SRC_DIV2) ||
		((wcfg.core_source_select == `SRC_DIV1) && !wcfg.vco_range_select));

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			clock_control_register_r <= {`RST_SRC, `RST_RANGE, `RST_MULT, `RST_PRE};
		end else if (ctl_wr) begin
			clock_control_register_r <= wcfg;
		end
	end

	// A rejected setting leaves the clock tree on the last good one.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			applied_r <= {`RST_SRC, `RST_RANGE, `RST_MULT, `RST_PRE};
			apply_r   <= 1'b0;
		end else begin
			apply_r <= ctl_wr && wcfg_ok;
			if (ctl_wr && wcfg_ok) begin
				applied_r <= wcfg;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			config_error <= 1'b0;
		end else if (ctl_wr) begin
			config_error <= !wcfg_ok;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd && reg_addr == `OFS_CLK_CTL) begin
			reg_rdata <= 32'h0000_0000;
			reg_rdata[`PRE_MSB:`PRE_LSB]   <= clock_control_register_r.pre_divide_factor;
			reg_rdata[`MULT_MSB:`MULT_LSB] <= clock_control_register_r.loop_multiply_factor;
			reg_rdata[`RANGE_BIT]          <= clock_control_register_r.vco_range_select;
			reg_rdata[`SRC_MSB:`SRC_LSB]   <= clock_control_register_r.core_source_select;
		end else if (reg_rd && reg_addr == `OFS_CLK_STATUS) begin
			reg_rdata <= 32'h0000_0000;
			reg_rdata[`ST_ERR_BIT]             <= config_error;
			reg_rdata[`ST_DIV_MSB:`ST_DIV_LSB] <= clk_ratio.core_division;
			reg_rdata[`ST_MULT_MSB:`ST_MULT_LSB] <= clk_ratio.loop_multiplier;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ****************************************************************
	// Ratio derivation
	// ****************************************************************
	always_comb begin
		if (applied_r.core_source_select == `SRC_DIV1) begin
			div_nxt = 3'h2;
		end else if (applied_r.vco_range_select) begin
			div_nxt = 3'h2;
		end else begin
			div_nxt = 3'h4;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			clk_ratio <= '0;
		end else begin
			clk_ratio.loop_multiplier <= {1'b0, applied_r.loop_multiply_factor} + 9'h001;
			clk_ratio.vco_halved      <= !applied_r.vco_range_select;
			clk_ratio.core_division   <= div_nxt;
		end
	end

	// The divider restarts on every new setting so no short pulse escapes.
	tick_divider u_pre_divider (
		.sys_clk (sys_clk),
		.srst    (srst),
		.restart (apply_r),
		.ratio   (applied_r.pre_divide_factor),
		.tick    (pre_div_tick)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	logic [5:0] since_r;
	logic       first_r;

	always_ff @(posedge sys_clk) begin
		if (srst || apply_r) begin
			since_r <= 6'h00;
			first_r <= 1'b1;
		end else if (pre_div_tick) begin
			since_r <= 6'h00;
			first_r <= 1'b0;
		end else begin
			since_r <= since_r + 6'h01;
		end
	end

	property p_tick_period;
		pre_div_tick && !apply_r |-> since_r == {1'b0, applied_r.pre_divide_factor} + {5'h00, first_r};
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("pre-divide period wrong");

	property p_tick_single;
		pre_div_tick && applied_r.pre_divide_factor != 5'h00 |=> !pre_div_tick;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("pre-divide pulse too long");

	property p_loop_mult;
		ctl_wr && wcfg_ok ##1 !ctl_wr [*2]
			|-> clk_ratio.loop_multiplier == {1'b0, $past(wcfg.loop_multiply_factor, 2)} + 9'h001;
	endproperty
	a_loop_mult: assert property (p_loop_mult) else $error("loop multiplier mismatch");

	property p_range_halve;
		ctl_wr && wcfg_ok ##2 1'b1 |-> clk_ratio.vco_halved == !$past(wcfg.vco_range_select, 2);
	endproperty
	a_range_halve: assert property (p_range_halve) else $error("range halving wrong");

	property p_div4;
		ctl_wr && wcfg_ok && wcfg.core_source_select == `SRC_DIV2 && !wcfg.vco_range_select
			|-> ##2 clk_ratio.core_division == 3'h4;
	endproperty
	a_div4: assert property (p_div4) else $error("divide by four not applied");

	property p_div2;
		ctl_wr && wcfg_ok && (wcfg.core_source_select == `SRC_DIV1 || wcfg.vco_range_select)
			|-> ##2 clk_ratio.core_division == 3'h2;
	endproperty
	a_div2: assert property (p_div2) else $error("divide by two not applied");

	property p_reserved_rejected;
		ctl_wr && wcfg.core_source_select == `SRC_DIV1 && wcfg.vco_range_select
			|=> config_error && $stable(applied_r);
	endproperty
	a_reserved_rejected: assert property (p_reserved_rejected) else $error("reserved setting applied");

	property p_pre_range;
		ctl_wr && wcfg.pre_divide_factor > `PRE_MAX |=> config_error && $stable(applied_r);
	endproperty
	a_pre_range: assert property (p_pre_range) else $error("pre-divide out of range applied");

	property p_range_path;
		$changed(applied_r.vco_range_select)
			|=> clk_ratio.vco_halved != $past(applied_r.vco_range_select);
	endproperty
	a_range_path: assert property (p_range_path) else $error("range select not followed");

	property p_mult_path;
		$changed(applied_r.loop_multiply_factor) |=> clk_ratio.loop_multiplier != 9'h000;
	endproperty
	a_mult_path: assert property (p_mult_path) else $error("multiplier output zero");

endmodule // pll_clock_configuration

// >>> tb_top.sv
// Self-checking testbench for the PLL clock configuration block.
// Assumes the package, the constants header and the design modules are compiled first.
`timescale 1ns/1ps
`include "pll_clk_cfg.svh"

module tb_top;
	import pll_clk_pkg::*;

	logic               sys_clk = 1'b0;
	logic               srst = 1'b1;
	logic [`ADDR_W-1:0] reg_addr = '0;
	logic [31:0]        reg_wdata = '0;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic [31:0]        reg_rdata;
	logic               pre_div_tick;
	clk_ratio_s         clk_ratio;
	logic               config_error;
	int                 miscompares = 0;
	int                 checked = 0;

	always #25 sys_clk = ~sys_clk;

	pll_clock_configuration i_dut (
		.sys_clk      (sys_clk),
		.srst         (srst),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_wr       (reg_wr),
		.reg_rd       (reg_rd),
		.reg_rdata    (reg_rdata),
		.pre_div_tick (pre_div_tick),
		.clk_ratio    (clk_ratio),
		.config_error (config_error)
	);

	// ****************************************************************
	// Bus cycles, expectations and comparison
	// ****************************************************************
	task automatic report_and_stop();
		if (miscompares == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Waits for one tick, then counts the cycles up to the next one.
	task automatic tick_gap(input int exp);
		int i;
		int g;
		i = 0;
		g = 0;
		do begin
			@(posedge sys_clk);
			#1 i++;
		end while (pre_div_tick !== 1'b1 && i < 40);
		do begin
			@(posedge sys_clk);
			#1 g++;
		end while (pre_div_tick !== 1'b1 && g < 40);
		if (g >= 40) begin
			miscompares++;
			report_and_stop();
		end
		chk("tick_period", exp, g);
	endtask

	function automatic logic [31:0] ctl(logic [4:0] p, logic [7:0] m, logic r, logic [1:0] s);
		return {13'h0, s, r, m, 3'h0, p};
	endfunction

	// Applies and checks one setting; the status word repeats the loop multiplier and the core division.
	task automatic apply_ok(input logic [4:0] p, input logic [7:0] m, input logic r,
		input logic [1:0] s, input logic [2:0] dv);
		logic [31:0] d;
		wr(`OFS_CLK_CTL, ctl(p, m, r, s));
		repeat (2) @(posedge sys_clk);
		#1 chk("config_error", 32'h0, {31'h0, config_error});
		chk("clk_ratio", {19'h0, {1'b0, m} + 9'h001, ~r, dv}, {19'h0, clk_ratio});
		rd(`OFS_CLK_CTL, d);
		chk("ctl_readback", ctl(p, m, r, s), d);
		rd(`OFS_CLK_STATUS, d);
		chk("status", {19'h0, {1'b0, m} + 9'h001, dv, 1'b0}, d);
		tick_gap(int'(p) + 1);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		logic [31:0] d;
		rd(`OFS_CLK_CTL, d);
		chk("ctl_reset", 32'h0002_1300, d);
		chk("ratio_reset", {19'h0, 9'h014, 1'b1, 3'h4}, {19'h0, clk_ratio});
		rd(`OFS_CLK_STATUS, d);
		chk("status_reset", 32'h0000_0148, d);
		@(posedge sys_clk);
		#1 chk("rdata_idle", 32'h0, reg_rdata);
		tick_gap(1);
	endtask

	// Every legal source and range pair, with boundary divide and multiply values.
	task automatic t_modes();
		apply_ok(5'h08, 8'hff, 1'b0, 2'h3, 3'h2);
		apply_ok(5'h00, 8'h00, 1'b1, 2'h1, 3'h2);
		// The last two suit a 75 or 45 MHz reference: 15 MHz into the loop, 450 or 300 MHz out.
		apply_ok(5'h04, 8'h1d, 1'b0, 2'h1, 3'h4);
		apply_ok(5'h02, 8'h13, 1'b1, 2'h1, 3'h2);
	endtask

	// Refused settings read back but leave the applied ratios and ticks alone.
	task automatic t_reject();
		logic [31:0] bad [4];
		logic [31:0] d;
		bad = '{ctl(5'h09, 8'h10, 1'b0, 2'h1), ctl(5'h00, 8'h10, 1'b1, 2'h3),
			ctl(5'h00, 8'h10, 1'b0, 2'h0), ctl(5'h00, 8'h10, 1'b0, 2'h2)};
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_CLK_CTL, bad[i]);
			repeat (2) @(posedge sys_clk);
			#1 chk("reject_error", 32'h1, {31'h0, config_error});
			chk("reject_ratio", {19'h0, 9'h014, 1'b0, 3'h2}, {19'h0, clk_ratio});
			rd(`OFS_CLK_CTL, d);
			chk("reject_readback", bad[i], d);
			tick_gap(3);
		end
		wr(8'h08, 32'hffff_ffff);
		rd(8'h08, d);
		chk("unmapped_read", 32'h0, d);
		apply_ok(5'h01, 8'h0f, 1'b1, 2'h1, 3'h2);
	endtask

	initial begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset();
		t_modes();
		t_reject();
		report_and_stop();
	end

endmodule // tb_top
